// ===== osr_device.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
// Contract
// - OTP read opcode, MSB first, eight clocks
// - 24-bit address, low nine bits used
// - One dummy byte before OTP data
// - One byte per eight clocks, MSB first
// - OTP read runs through all four registers
// - Bits 8:7 register, bits 6:0 byte
// - Direct status reads, no address or dummy
// - Direct status read repeats same byte
// - Each repeat samples live register value
// - Chip select high ends read, output released
// - Indirect read: opcode, address, dummy, data
// - Addresses 01h-05h select status bytes 1-5
// - Address increments after each byte
// - Register 1 data on clocks 24-31
// - Addresses 6-255 return undefined data
// - Eight-bit address wraps FFh to 00h
// - Chip select high ends indirect read immediately
module osr_device #(
    parameter int OTP_DEPTH = osr_pkg::OTP_BYTES
) (
    input  wire logic       clock,
    input  wire logic       nrst,
    osr_link_if.device      link,
    input  wire logic [39:0] statusIn,
    input  wire logic       otpWrEn,
    input  wire logic [8:0] otpWrAddr,
    input  wire logic [7:0] otpWrData,
    output logic [7:0]      lastOpcode
);
    typedef enum logic [5:0] {
        ST_OPC   = 6'b000001,
        ST_ADDR  = 6'b000010,
        ST_DUMMY = 6'b000100,
        ST_DATA  = 6'b001000,
        ST_IDLE  = 6'b010000,
        ST_SKIP  = 6'b100000
    } osr_state_type;

    typedef enum logic [2:0] {
        KIND_OTP  = 3'b001,
        KIND_DIR  = 3'b010,
        KIND_IND  = 3'b100
    } osr_kind_type;

    logic [7:0] otpMem [OTP_DEPTH];
    logic [1:0] csSync_q;
    logic [2:0] sckSync_q;
    logic [1:0] siSync_q;
    logic       csActive;
    logic       sckRise;
    logic       sckFall;
    osr_state_type state_q;
    osr_kind_type  kind_q;
    logic [4:0]  bitCnt_q;
    logic [7:0]  shiftIn_q;
    logic [23:0] addr_q;
    logic [8:0]  otpPtr_q;
    logic [7:0]  statAddr_q;
    logic [1:0]  dirSel_q;
    logic [7:0]  outByte_q;
    logic [2:0]  outBit_q;
    logic        serOut_q;
    logic        serOutEn_q;
    logic [7:0]  shiftNext;
    logic [7:0]  fetchByte;

    // Picks a status byte by its indirect address; other addresses read as zero.
    function automatic logic [7:0] statByte(input logic [7:0] a, input logic [39:0] s);
        case (a)
            osr_pkg::STAT_ADDR_ONE:   statByte = s[7:0];
            osr_pkg::STAT_ADDR_TWO:   statByte = s[15:8];
            osr_pkg::STAT_ADDR_THREE: statByte = s[23:16];
            osr_pkg::STAT_ADDR_FOUR:  statByte = s[31:24];
            osr_pkg::STAT_ADDR_FIVE:  statByte = s[39:32];
            default:                  statByte = 8'h00;
        endcase
    endfunction

    // Link pins come from another domain: two flops, the third only for edges.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            csSync_q  <= 2'h3;
            sckSync_q <= 3'h0;
            siSync_q  <= 2'h0;
        end else begin
            csSync_q  <= {csSync_q[0], link.chipSelN};
            sckSync_q <= {sckSync_q[1:0], link.serClk};
            siSync_q  <= {siSync_q[0], link.serIn};
        end
    end

    assign csActive  = !csSync_q[1];
    assign sckRise   = sckSync_q[1] && !sckSync_q[2];
    assign sckFall   = !sckSync_q[1] && sckSync_q[2];
    assign shiftNext = {shiftIn_q[6:0], siSync_q[1]};

    // Source of the next output byte, picked by the command kind.
    always_comb begin
        case (kind_q)
            KIND_OTP: fetchByte = otpMem[otpPtr_q];
            KIND_IND: fetchByte = statByte(statAddr_q, statusIn);
            default:  fetchByte = statByte({6'h00, dirSel_q}, statusIn);
        endcase
    end

    // OTP content is loaded by the programming side; reads come from here.
    always_ff @(posedge clock) begin
        if (otpWrEn) begin
            otpMem[otpWrAddr] <= otpWrData;
        end
    end

    // Command sequencer, advanced on rising serial clock edges.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q    <= ST_IDLE;
            kind_q     <= KIND_OTP;
            bitCnt_q   <= 5'h00;
            shiftIn_q  <= 8'h00;
            addr_q     <= 24'h000000;
            otpPtr_q   <= 9'h000;
            statAddr_q <= 8'h00;
            dirSel_q   <= 2'h0;
            lastOpcode <= 8'h00;
        end else if (!csActive) begin
            state_q  <= ST_OPC;
            bitCnt_q <= 5'h00;
        end else if (sckRise) begin
            bitCnt_q  <= bitCnt_q + 5'h01;
            shiftIn_q <= shiftNext;
            case (state_q)
                ST_OPC: begin
                    if (bitCnt_q == 5'(osr_pkg::OPC_BITS - 1)) begin
                        bitCnt_q   <= 5'h00;
                        lastOpcode <= shiftNext;
                        state_q    <= ST_SKIP;
                        case (shiftNext)
                            osr_pkg::OPC_OTP_READ: begin
                                kind_q  <= KIND_OTP;
                                state_q <= ST_ADDR;
                            end
                            osr_pkg::OPC_STAT_IND: begin
                                kind_q  <= KIND_IND;
                                state_q <= ST_ADDR;
                            end
                            osr_pkg::OPC_STAT1, osr_pkg::OPC_STAT2,
                            osr_pkg::OPC_STAT3: begin
                                kind_q   <= KIND_DIR;
                                state_q  <= ST_DATA;
                                dirSel_q <= (shiftNext == osr_pkg::OPC_STAT1) ? 2'h1 :
                                            (shiftNext == osr_pkg::OPC_STAT2) ? 2'h2 : 2'h3;
                            end
                            default: state_q <= ST_SKIP;
                        endcase
                    end
                end
                ST_ADDR: begin
                    addr_q <= {addr_q[22:0], siSync_q[1]};
                    if ((kind_q == KIND_OTP &&
                         bitCnt_q == 5'(osr_pkg::OTP_ADDR_BITS - 1)) ||
                        (kind_q == KIND_IND &&
                         bitCnt_q == 5'(osr_pkg::BYTE_BITS - 1))) begin
                        bitCnt_q   <= 5'h00;
                        state_q    <= ST_DUMMY;
                        otpPtr_q   <= {addr_q[7:0], siSync_q[1]};
                        statAddr_q <= shiftNext;
                    end
                end
                ST_DUMMY: begin
                    if (bitCnt_q == 5'(osr_pkg::BYTE_BITS - 1)) begin
                        bitCnt_q <= 5'h00;
                        state_q  <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (bitCnt_q == 5'(osr_pkg::BYTE_BITS - 1)) begin
                        bitCnt_q <= 5'h00;
                        // Pointer wraps over all four registers, then restarts.
                        otpPtr_q   <= otpPtr_q + 9'h001;
                        statAddr_q <= statAddr_q + 8'h01;
                    end
                end
                ST_SKIP: bitCnt_q <= 5'h00;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Output shifter, changes on falling serial clock edges.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            outByte_q  <= 8'h00;
            outBit_q   <= 3'h7;
            serOut_q   <= 1'b0;
            serOutEn_q <= 1'b0;
        end else if (!csActive || state_q != ST_DATA) begin
            outBit_q   <= 3'h7;
            serOutEn_q <= 1'b0;
        end else if (sckFall) begin
            serOutEn_q <= 1'b1;
            if (outBit_q == 3'h7) begin
                // A fresh byte is fetched at every byte start, so status is live.
                outByte_q <= fetchByte;
                serOut_q  <= fetchByte[7];
            end else begin
                serOut_q <= outByte_q[outBit_q];
            end
            outBit_q <= outBit_q - 3'h1;
        end
    end

    assign link.serOut   = serOut_q;
    assign link.serOutEn = serOutEn_q;
endmodule

// ===== osr_host.sv
`timescale 1ns/10ps
// Host end: APB-programmed SPI master issuing the device's read commands.
module osr_host (
    input  wire logic        clock,
    input  wire logic        nrst,
    osr_link_if.host         link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    typedef enum logic [2:0] {
        HS_IDLE = 3'b001,
        HS_LOW  = 3'b010,
        HS_HIGH = 3'b100
    } osr_hstate_type;

    osr_hstate_type hState_q;
    logic [1:0] soSync_q;
    logic [7:0] txByte_q;
    logic [7:0] rxByte_q;
    logic [7:0] rxShift_q;
    logic [2:0] bitIdx_q;
    logic [3:0] divCnt_q;
    logic       busy_q;
    logic       byteDone_q;
    logic       csN_q;
    logic       sck_q;
    logic       si_q;
    logic       tick;
    logic       apbWr;
    logic       startReq;

    assign apbWr    = psel && penable && pwrite;
    assign startReq = apbWr && paddr == osr_pkg::REG_CMD && !busy_q;
    assign tick     = divCnt_q == 4'(osr_pkg::SCK_HALF_CYC - 1);

    // Returned serial data is from the device's domain: two flops.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            soSync_q <= 2'h3;
        end else begin
            soSync_q <= {soSync_q[0], link.serOutWire};
        end
    end

    // Divider making the serial clock's half-period enable.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            divCnt_q <= 4'h0;
        end else if (tick || hState_q == HS_IDLE) begin
            divCnt_q <= 4'h0;
        end else begin
            divCnt_q <= divCnt_q + 4'h1;
        end
    end

    // Byte engine: mode 0, output on falling, sample on rising.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hState_q   <= HS_IDLE;
            bitIdx_q   <= 3'h7;
            sck_q      <= 1'b0;
            si_q       <= 1'b0;
            busy_q     <= 1'b0;
            byteDone_q <= 1'b0;
            rxShift_q  <= 8'h00;
            rxByte_q   <= 8'h00;
        end else begin
            case (hState_q)
                HS_IDLE: begin
                    if (startReq) begin
                        busy_q     <= 1'b1;
                        byteDone_q <= 1'b0;
                        bitIdx_q   <= 3'h7;
                        si_q       <= txByte_q[7];
                        hState_q   <= HS_LOW;
                    end
                end
                HS_LOW: begin
                    if (tick) begin
                        sck_q     <= 1'b1;
                        rxShift_q <= {rxShift_q[6:0], soSync_q[1]};
                        hState_q  <= HS_HIGH;
                    end
                end
                HS_HIGH: begin
                    if (tick) begin
                        sck_q <= 1'b0;
                        if (bitIdx_q == 3'h0) begin
                            rxByte_q   <= rxShift_q;
                            busy_q     <= 1'b0;
                            byteDone_q <= 1'b1;
                            hState_q   <= HS_IDLE;
                        end else begin
                            bitIdx_q <= bitIdx_q - 3'h1;
                            si_q     <= txByte_q[bitIdx_q - 3'h1];
                            hState_q <= HS_LOW;
                        end
                    end
                end
                default: hState_q <= HS_IDLE;
            endcase
        end
    end

    // Software registers: chip select control and byte to send.
    // Chip select is kept active low in its flop so the pin comes straight from it.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            csN_q    <= 1'b1;
            txByte_q <= 8'h00;
        end else if (apbWr && paddr == osr_pkg::REG_CTRL) begin
            csN_q <= !pwdata[0];
        end else if (apbWr && paddr == osr_pkg::REG_TXDATA) begin
            txByte_q <= pwdata[7:0];
        end
    end

    // APB answers in the first access cycle; reads are registered.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            case (paddr)
                osr_pkg::REG_CTRL:   prdata <= {31'h0, !csN_q};
                osr_pkg::REG_TXDATA: prdata <= {24'h0, txByte_q};
                osr_pkg::REG_RXDATA: prdata <= {24'h0, rxByte_q};
                osr_pkg::REG_STATUS: prdata <= {30'h0, byteDone_q, busy_q};
                osr_pkg::REG_CMD:    prdata <= 32'h0000_0000;
                default:             prdata <= osr_pkg::UNMAPPED_DATA;
            endcase
        end
    end

    assign link.chipSelN = csN_q;
    assign link.serClk   = sck_q;
    assign link.serIn    = si_q;
endmodule

// ===== osr_link_if.sv
`timescale 1ns/10ps
interface osr_link_if;
    logic chipSelN;
    logic serClk;
    logic serIn;
    logic serOut;
    logic serOutEn;
    logic serOutWire;

    // Line level seen by the host: low-impedance only while the device drives.
    assign serOutWire = serOutEn ? serOut : 1'b1;

    modport device (
        input  chipSelN,
        input  serClk,
        input  serIn,
        output serOut,
        output serOutEn
    );
    modport host (
        output chipSelN,
        output serClk,
        output serIn,
        input  serOutWire
    );
endinterface

// ===== osr_link_properties.sv
`timescale 1ns/10ps
// Watches the serial link between the two ends and counts clock rises within a frame.
module osr_link_properties (
    input wire logic clock,
    input wire logic nrst,
    input wire logic chipSelN,
    input wire logic serClk,
    input wire logic serIn,
    input wire logic serOut,
    input wire logic serOutEn,
    input wire logic serOutWire
);
    logic       serClk_q;
    logic [7:0] riseCnt_q;
    logic [7:0] opc_q;
    logic [2:0] idle_q;
    logic       direct;

    // The rise counter saturates, so a long read never wraps back into the opcode phase.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            serClk_q <= 1'b0;
            riseCnt_q <= 8'h00;
            opc_q <= 8'h00;
        end else begin
            serClk_q <= serClk;
            if (chipSelN) begin
                riseCnt_q <= 8'h00;
                opc_q <= 8'h00;
            end else if (serClk && !serClk_q) begin
                riseCnt_q <= (riseCnt_q == 8'hff) ? riseCnt_q : riseCnt_q + 8'h01;
                if (riseCnt_q < 8'h08) begin
                    opc_q <= {opc_q[6:0], serIn};
                end
            end
        end
    end

    // Counts idle cycles after chip select rises; the device may lag a few cycles.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            idle_q <= 3'h0;
        end else if (!chipSelN) begin
            idle_q <= 3'h0;
        end else if (idle_q != 3'h7) begin
            idle_q <= idle_q + 3'h1;
        end
    end

    // Opcodes of the three direct status reads.
    assign direct = (opc_q == osr_pkg::OPC_STAT1) || (opc_q == osr_pkg::OPC_STAT2) ||
                    (opc_q == osr_pkg::OPC_STAT3);

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    cs_release_a: assert property ($rose(chipSelN) |-> ##[0:4] !serOutEn)
        else $error("output still driven after chip select rose");
    end_on_cs_a: assert property ($fell(serOutEn) |-> chipSelN)
        else $error("output released while chip select low");
    idle_quiet_a: assert property (idle_q == 3'h7 |-> !serOutEn)
        else $error("output driven outside a frame");
    opcode_quiet_a: assert property (serOutEn && !chipSelN |-> riseCnt_q >= 8'h08)
        else $error("output driven during opcode");
    otp_dummy_a: assert property (serOutEn && !chipSelN && opc_q == osr_pkg::OPC_OTP_READ
        |-> riseCnt_q >= 8'h28)
        else $error("otp data before address and dummy done");
    ind_dummy_a: assert property (serOutEn && !chipSelN && opc_q == osr_pkg::OPC_STAT_IND
        |-> riseCnt_q >= 8'h18)
        else $error("indirect data before address and dummy done");
    known_only_a: assert property (serOutEn && !chipSelN |-> direct ||
        opc_q == osr_pkg::OPC_OTP_READ || opc_q == osr_pkg::OPC_STAT_IND)
        else $error("output driven for unknown opcode");
    direct_start_a: assert property (direct && !chipSelN && riseCnt_q == 8'h0a |-> serOutEn)
        else $error("direct status data not driven after opcode");
    clk_idle_a: assert property (chipSelN |-> !serClk)
        else $error("serial clock high outside a frame");
    clk_hold_a: assert property ($rose(serClk) |=> serClk)
        else $error("serial clock high phase too short");
endmodule

// ===== osr_pkg.sv
package osr_pkg;
    // Opcodes handled by the device end.
    localparam logic [7:0] OPC_OTP_READ  = 8'h4b;
    localparam logic [7:0] OPC_STAT1     = 8'h05;
    localparam logic [7:0] OPC_STAT2     = 8'h35;
    localparam logic [7:0] OPC_STAT3     = 8'h15;
    localparam logic [7:0] OPC_STAT_IND  = 8'h65;
    // Status register addresses for the indirect read.
    localparam logic [7:0] STAT_ADDR_ONE   = 8'h01;
    localparam logic [7:0] STAT_ADDR_TWO   = 8'h02;
    localparam logic [7:0] STAT_ADDR_THREE = 8'h03;
    localparam logic [7:0] STAT_ADDR_FOUR  = 8'h04;
    localparam logic [7:0] STAT_ADDR_FIVE  = 8'h05;
    // Framing counts in serial clock edges, then OTP pointer width and OTP size in bytes.
    localparam int OPC_BITS      = 8;
    localparam int OTP_ADDR_BITS = 24;
    localparam int OTP_PTR_BITS  = 9;
    localparam int OTP_BYTES     = 512;
    localparam int BYTE_BITS     = 8;
    // Fields of the OTP pointer.
    localparam int OTP_BYTE_MSB  = 6;
    localparam int OTP_SEL_MSB   = 8;
    localparam int OTP_SEL_LSB   = 7;
    // Host clock divider: half period of the serial clock in system cycles.
    // The device answers a falling edge only after about five cycles of sync and
    // shift lag, so a half period under six cycles would make the host sample a stale bit.
    localparam int SCK_HALF_CYC  = 8;
    // Host APB register offsets.
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CMD    = 8'h04;
    localparam logic [7:0] REG_TXDATA = 8'h08;
    localparam logic [7:0] REG_RXDATA = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// ===== otp_and_status_read_commands_tb_top.sv
`timescale 1ns/10ps
// Drives the host over APB and the device's status and OTP inputs; checks what comes back.
module otp_and_status_read_commands_tb_top;
    logic        clock;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [39:0] statusIn;
    logic        otpWrEn;
    logic [8:0]  otpWrAddr;
    logic [7:0]  otpWrData;
    logic [7:0]  lastOpcode;
    logic        watchRd;
    logic [31:0] seed;
    logic [31:0] rd;
    logic [7:0]  otpMem [512];
    logic [31:0] expQ [$];
    int          n_mismatch;
    int          check_count;

    osr_link_if lnk ();
    osr_device osr_device_i (.clock(clock), .nrst(nrst), .link(lnk), .statusIn(statusIn),
        .otpWrEn(otpWrEn), .otpWrAddr(otpWrAddr), .otpWrData(otpWrData),
        .lastOpcode(lastOpcode));
    osr_host osr_host_i (.clock(clock), .nrst(nrst), .link(lnk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    osr_link_properties osr_link_properties_i (.clock(clock), .nrst(nrst),
        .chipSelN(lnk.chipSelN), .serClk(lnk.serClk), .serIn(lnk.serIn),
        .serOut(lnk.serOut), .serOutEn(lnk.serOutEn), .serOutWire(lnk.serOutWire));

    // System clock of 100 ns.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        watchRd <= c;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        watchRd <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
    endtask

    // Sends one byte; when c is set the expected byte e is noted and the byte heard back read for the watcher.
    task automatic xfer(input logic [7:0] b, input logic [7:0] e, input logic c);
        int n;
        n = 0;
        apb(1'b1, osr_pkg::REG_TXDATA, {24'h0, b}, 1'b0);
        apb(1'b1, osr_pkg::REG_CMD, 32'h1, 1'b0);
        do begin
            apb(1'b0, osr_pkg::REG_STATUS, 32'h0, 1'b0);
            n++;
        end while (rd[0] !== 1'b0 && n < 100);
        if (rd[0] !== 1'b0) begin
            n_mismatch++;
            end_sim();
        end
        if (c) begin
            expQ.push_back({24'h0, e});
            apb(1'b0, osr_pkg::REG_RXDATA, 32'h0, 1'b1);
        end
    endtask

    // Ends a frame and waits past the device's lag before looking at the idle line.
    task automatic cs_off();
        apb(1'b1, osr_pkg::REG_CTRL, 32'h0, 1'b0);
        repeat (10) @(posedge clock);
        check("idle line", {31'h0, lnk.serOutWire}, 32'h1);
        check("idle enable", {31'h0, lnk.serOutEn}, 32'h0);
    endtask

    // Takes the oldest note whenever a watched read completes.
    always @(posedge clock) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && watchRd === 1'b1) begin
            if (expQ.size() == 0) begin
                check("rxdata note", 32'h0, 32'h1);
            end else begin
                check("rxdata", prdata, expQ.pop_front());
            end
        end
    end

    // A hang anywhere ends the run as a failure.
    initial begin
        repeat (100000) @(posedge clock);
        n_mismatch++;
        end_sim();
    end

    initial begin
        logic [7:0]  ops [3];
        logic [31:0] rnd;
        logic [23:0] addr;
        logic [7:0]  cur;
        int          idx;
        ops = '{osr_pkg::OPC_STAT1, osr_pkg::OPC_STAT2, osr_pkg::OPC_STAT3};
        {nrst, psel, penable, pwrite, watchRd, otpWrEn} = 6'h00;
        {paddr, pwdata, otpWrAddr, otpWrData, statusIn} = '0;
        seed = 32'd89;
        n_mismatch = 0;
        check_count = 0;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        // Random OTP content, mirrored here as the expectation.
        for (int i = 0; i < 512; i++) begin
            rnd = xs();
            @(posedge clock);
            otpWrEn <= 1'b1;
            otpWrAddr <= i[8:0];
            otpWrData <= rnd[7:0];
            otpMem[i] = rnd[7:0];
        end
        rnd = xs();
        @(posedge clock);
        otpWrEn <= 1'b0;
        statusIn <= {rnd[7:0], xs()};
        apb(1'b0, 8'h20, 32'h0, 1'b0);
        check("unmapped", rd, osr_pkg::UNMAPPED_DATA);
        // Direct reads: the byte repeats and a second pass shows the updated value.
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, osr_pkg::REG_CTRL, 32'h1, 1'b0);
            // The first data byte is fetched as the opcode ends, so the change
            // made here may only show in the repeat that follows it.
            xfer(ops[k], 8'hff, 1'b1);
            cur = statusIn[8*k +: 8];
            rnd = xs();
            statusIn <= {statusIn[39:32], rnd};
            @(posedge clock);
            xfer(8'h00, cur, 1'b1);
            xfer(8'h00, statusIn[8*k +: 8], 1'b1);
            cs_off();
            check("opcode", {24'h0, lastOpcode}, {24'h0, ops[k]});
        end
        // Indirect reads from 01h and from FFh, crossing undefined space and the wrap.
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, osr_pkg::REG_CTRL, 32'h1, 1'b0);
            cur = (k == 0) ? osr_pkg::STAT_ADDR_ONE : 8'hff;
            xfer(osr_pkg::OPC_STAT_IND, 8'hff, 1'b1);
            xfer(cur, 8'hff, 1'b1);
            xfer(8'h00, 8'hff, 1'b1);
            for (int j = 0; j < 6; j++) begin
                idx = int'(cur);
                xfer(8'h00, (idx >= 1 && idx <= 5) ? statusIn[8*(idx-1) +: 8] : 8'h00, 1'b1);
                cur = cur + 8'h01;
            end
            cs_off();
        end
        // OTP read from the last byte of register two into register three.
        rnd = xs();
        addr = {rnd[14:0], 9'h17f};
        apb(1'b1, osr_pkg::REG_CTRL, 32'h1, 1'b0);
        xfer(osr_pkg::OPC_OTP_READ, 8'hff, 1'b1);
        for (int j = 2; j >= 0; j--) begin
            xfer(addr[8*j +: 8], 8'hff, 1'b1);
        end
        xfer(8'h00, 8'hff, 1'b1);
        xfer(8'h00, otpMem[9'h17f], 1'b1);
        xfer(8'h00, otpMem[9'h180], 1'b1);
        cs_off();
        // An unknown opcode leaves the line released.
        apb(1'b1, osr_pkg::REG_CTRL, 32'h1, 1'b0);
        xfer(8'ha5, 8'hff, 1'b1);
        xfer(8'h00, 8'hff, 1'b1);
        cs_off();
        check("pending", expQ.size(), 32'h0);
        end_sim();
    end
endmodule
